//--- rtl/rsl_top.sv
/*
 Receive slip-buffer interrupt enables, sticky slip status, loop-up
 code pattern and live detection status, behind an Avalon-MM slave.
 Assumes slip-buffer strobes come from logic on clk_i and the
 loop-up detect flag comes from the receive line clock domain.
*/
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/10ps
module rsl_top
    import rsl_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [AW-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [DW-1:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [DW-1:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic rx_sb_write_i,
    input wire logic rx_sb_read_i,
    input wire logic rx_sb_full_i,
    input wire logic rx_sb_empty_i,
    input wire logic loop_up_detect_i,
    output logic rx_frame_drop_o,
    output logic rx_frame_repeat_o,
    output logic [RW-1:0] loop_up_code_pattern_o,
    output logic loop_up_detect_en_o,
    output logic irq_o
);

    ////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic [NSRC-1:0] en;
        logic [RW-1:0] pattern;
        logic det_en;
        logic det;
        logic wait_req;
        logic [RW-1:0] rdata;
        logic irq;
        logic drop;
        logic rpt;
    } rsl_state_t;

    rsl_state_t s_q;
    rsl_state_t s_d;

    logic det_sync;
    logic [NSRC-1:0] stat;
    logic [NSRC-1:0] stat_set;
    logic [NSRC-1:0] stat_clr;
    logic req;
    logic capture;
    logic done;
    logic wr_done;
    logic rd_done;
    logic full_ev;
    logic empty_ev;

    ////////////////////////////////////////////////////////////
    // Decode helper

    // True when the address selects the given register
    function automatic logic hit(input logic [AW-1:0] a,
                                 input logic [AW-1:0] idx);
        hit = (a == idx);
    endfunction

    // Read multiplexer; unmapped reads return zero
    function automatic logic [RW-1:0] rd_mux(input logic [AW-1:0] a,
                                             input rsl_state_t s,
                                             input logic [NSRC-1:0] st);
        logic [RW-1:0] v;
        v = '0;
        if (hit(a, IDX_SLIP_EN)) begin
            v[NSRC-1:0] = s.en;
        end else if (hit(a, IDX_LOOP_ST)) begin
            v[DETECT_BIT] = s.det;
        end else if (hit(a, IDX_PATTERN)) begin
            v = s.pattern;
        end else if (hit(a, IDX_SLIP_ST)) begin
            v[NSRC-1:0] = st;
        end else if (hit(a, IDX_LOOP_CTRL)) begin
            v[DET_EN_BIT] = s.det_en;
        end
        rd_mux = v;
    endfunction

    ////////////////////////////////////////////////////////////
    // Sub-blocks

    // Detect flag crosses from the line clock
    rsl_sync2 #(
        .W(1)
    ) u_det_sync (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .d_i(loop_up_detect_i),
        .q_o(det_sync)
    );

    // Sticky slip status bits
    rsl_sticky #(
        .W(NSRC)
    ) u_status (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .set_i(stat_set),
        .clr_i(stat_clr),
        .q_o(stat)
    );

    ////////////////////////////////////////////////////////////
    // Bus handshake

    // Capture with waitrequest high, complete when low
    assign req = avs_read_i | avs_write_i;
    assign capture = req & s_q.wait_req;
    assign done = req & ~s_q.wait_req;
    assign wr_done = done & avs_write_i & avs_byteenable_i[0];
    assign rd_done = done & avs_read_i;

    ////////////////////////////////////////////////////////////
    // Slip events

    // Write into full buffer drops a frame
    assign full_ev = rx_sb_write_i & rx_sb_full_i;
    // Read from empty buffer repeats a frame
    assign empty_ev = rx_sb_read_i & rx_sb_empty_i;

    // Status set vector
    always_comb begin
        stat_set = '0;
        stat_set[FULL_BIT] = full_ev;
        stat_set[EMPTY_BIT] = empty_ev;
        stat_set[SLIP_BIT] = full_ev | empty_ev;
    end

    // Clear only bits that the read returned, or written ones
    always_comb begin
        stat_clr = '0;
        if (rd_done && hit(avs_address_i, IDX_SLIP_ST)) begin
            stat_clr = s_q.rdata[NSRC-1:0];
        end else if (wr_done && hit(avs_address_i, IDX_SLIP_ST)) begin
            stat_clr = avs_writedata_i[NSRC-1:0];
        end
    end

    ////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        s_d = s_q;
        // Waitrequest drops for one cycle per request
        if (capture) begin
            s_d.wait_req = 1'b0;
            s_d.rdata = rd_mux(avs_address_i, s_q, stat);
        end else begin
            s_d.wait_req = 1'b1;
        end
        // Register writes take effect on completion
        if (wr_done) begin
            if (hit(avs_address_i, IDX_SLIP_EN)) begin
                s_d.en = avs_writedata_i[NSRC-1:0];
            end else if (hit(avs_address_i, IDX_PATTERN)) begin
                s_d.pattern = avs_writedata_i[RW-1:0];
            end else if (hit(avs_address_i, IDX_LOOP_CTRL)) begin
                s_d.det_en = avs_writedata_i[DET_EN_BIT];
            end
        end
        // Live detection, gated by its enable
        s_d.det = s_q.det_en & det_sync;
        // Interrupt from enabled sticky bits
        s_d.irq = |(stat & s_q.en);
        // Frame drop and repeat commands to the buffer
        s_d.drop = full_ev;
        s_d.rpt = empty_ev;
    end

    ////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_q.en <= EN_RST;
            s_q.pattern <= PATTERN_RST;
            s_q.det_en <= DET_EN_RST;
            s_q.det <= 1'b0;
            s_q.wait_req <= 1'b1;
            s_q.rdata <= '0;
            s_q.irq <= 1'b0;
            s_q.drop <= 1'b0;
            s_q.rpt <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////
    // Outputs

    // Upper bits read as zero, reserved bits included
    assign avs_readdata_o = {{(DW-RW){1'b0}}, s_q.rdata};
    assign avs_waitrequest_o = s_q.wait_req;
    assign rx_frame_drop_o = s_q.drop;
    assign rx_frame_repeat_o = s_q.rpt;
    assign loop_up_code_pattern_o = s_q.pattern;
    assign loop_up_detect_en_o = s_q.det_en;
    assign irq_o = s_q.irq;

    ////////////////////////////////////////////////////////////
    // Checks

    // Full-buffer write flags status and drops a frame
    a_full_flags: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        full_ev |=> (stat[FULL_BIT] && stat[SLIP_BIT] && rx_frame_drop_o))
        else $error("full event not recorded");

    // Empty-buffer read flags status and repeats a frame
    a_empty_flags: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        empty_ev |=> (stat[EMPTY_BIT] && stat[SLIP_BIT] && rx_frame_repeat_o))
        else $error("empty event not recorded");

    // Slip status never rises without a slip event
    a_slip_cause: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        $rose(stat[SLIP_BIT]) |-> $past(full_ev || empty_ev))
        else $error("slip status rose without event");

    // Full interrupt follows when its enable is set
    a_full_irq: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (stat[FULL_BIT] && s_q.en[FULL_BIT]) |=> irq_o)
        else $error("full interrupt missing");

    // Empty interrupt follows when its enable is set
    a_empty_irq: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (stat[EMPTY_BIT] && s_q.en[EMPTY_BIT]) |=> irq_o)
        else $error("empty interrupt missing");

    // Slip interrupt follows when its enable is set
    a_slip_irq: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (stat[SLIP_BIT] && s_q.en[SLIP_BIT]) |=> irq_o)
        else $error("slip interrupt missing");

    // No interrupt while nothing enabled is pending
    a_irq_masked: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        ((stat & s_q.en) == '0) |=> !irq_o)
        else $error("interrupt without enabled status");

    // Enable write is visible in the next cycle
    a_en_write: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (wr_done && hit(avs_address_i, IDX_SLIP_EN))
        |=> (s_q.en == $past(avs_writedata_i[NSRC-1:0])))
        else $error("enable write lost");

    // Detection status is zero while detection is off
    a_det_gated: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (!s_q.det_en ##1 !s_q.det_en) |-> !s_q.det)
        else $error("detect shown while disabled");

    // Pattern write reaches the detection engine
    a_pattern_out: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (wr_done && hit(avs_address_i, IDX_PATTERN))
        |=> (loop_up_code_pattern_o == $past(avs_writedata_i[RW-1:0])))
        else $error("pattern write lost");

    // Reserved loop status bits read zero
    a_loop_resv: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (capture && hit(avs_address_i, IDX_LOOP_ST))
        |=> (avs_readdata_o[7:4] == 4'h0 && !avs_waitrequest_o))
        else $error("reserved bits not zero");

    // A read clears returned bits unless re-set
    a_read_clears: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (rd_done && hit(avs_address_i, IDX_SLIP_ST) && s_q.rdata[SLIP_BIT] && !full_ev && !empty_ev)
        |=> !stat[SLIP_BIT])
        else $error("slip status not cleared by read");

    // Waitrequest low lasts exactly one cycle
    a_wait_one: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        !avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low too long");

endmodule

//--- rtl/rsl_pkg.sv
/*
 Constants for the receive slip and loop-up code interrupt block.
 Assumes a 32-bit Avalon-MM slave with word addressing; register
 indices equal the word address, byte address is four times that.
*/
// Operation
// - Enable bit 2 gates buffer-full interrupt
// - Write to full buffer drops frame, flags
// - Enable bit 1 gates buffer-empty interrupt
// - Read of empty buffer repeats frame, flags
// - Enable bit 0 gates slip interrupt
// - Slip status set on drop or repeat
// - Enable bits read/write, reset to zero
// - Bit 3 shows live gated loop-up detection
// - Loop-up pattern register at index 0x126
// - Loop status bits 7-4 read zero
// - Slip status clears on status read
package rsl_pkg;

    ////////////////////////////////////////////////////////////
    // Bus geometry
    localparam int unsigned AW = 12;
    localparam int unsigned DW = 32;
    localparam int unsigned RW = 8;

    ////////////////////////////////////////////////////////////
    // Register indices (word addresses)
    localparam logic [AW-1:0] IDX_PATTERN = 12'h126;
    localparam logic [AW-1:0] IDX_SLIP_EN = 12'hb09;
    localparam logic [AW-1:0] IDX_LOOP_ST = 12'hb0a;
    localparam logic [AW-1:0] IDX_SLIP_ST = 12'hb10;
    localparam logic [AW-1:0] IDX_LOOP_CTRL = 12'hb11;

    ////////////////////////////////////////////////////////////
    // Field positions
    localparam int unsigned SLIP_BIT = 0;
    localparam int unsigned EMPTY_BIT = 1;
    localparam int unsigned FULL_BIT = 2;
    localparam int unsigned NSRC = 3;
    localparam int unsigned DETECT_BIT = 3;
    localparam int unsigned DET_EN_BIT = 0;

    ////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [NSRC-1:0] EN_RST = 3'h0;
    localparam logic [RW-1:0] PATTERN_RST = 8'h00;
    localparam logic DET_EN_RST = 1'b0;
    localparam int unsigned SYNC_STAGES = 2;

endpackage

//--- rtl/rsl_sync2.sv
/*
 Two-flop synchroniser for level signals.
 Assumes the input is a level held long enough to be seen.
*/
`timescale 1ns/10ps
module rsl_sync2 #(
    parameter int unsigned W = 1
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } rsl_sync_t;

    rsl_sync_t s_q;
    rsl_sync_t s_d;

    initial begin
        if (W < 1) $error("rsl_sync2: W must be at least 1");
    end

    // First stage feeds only the second
    always_comb begin
        s_d.meta = d_i;
        s_d.sync = s_q.meta;
    end

    // State register
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign q_o = s_q.sync;
endmodule

//--- rtl/rsl_sticky.sv
/*
 Vector of sticky status bits: set wins over clear.
 Assumes set and clear come from the same clock domain.
*/
`timescale 1ns/10ps
module rsl_sticky #(
    parameter int unsigned W = 3
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [W-1:0] set_i,
    input wire logic [W-1:0] clr_i,
    output logic [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] flag;
    } rsl_sticky_t;

    rsl_sticky_t s_q;
    rsl_sticky_t s_d;

    initial begin
        if (W < 1) $error("rsl_sticky: W must be at least 1");
    end

    // A set in the clearing cycle survives
    always_comb begin
        s_d.flag = set_i | (s_q.flag & ~clr_i);
    end

    // State register
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign q_o = s_q.flag;

    a_set_wins: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (|set_i) |=> ((q_o & $past(set_i)) == $past(set_i)))
        else $error("sticky bit lost a set");
endmodule

//--- verif/tb_top.sv
/*
 Self-checking bench for the receive slip and loop-up code block.
 Assumes the block answers every bus request and takes strobes on clk_i.
*/
`timescale 1ns/10ps
module tb_top;
import rsl_pkg::*;

logic clk_i, rst_b_i, avs_read_i, avs_write_i, rx_sb_write_i, rx_sb_read_i;
logic rx_sb_full_i, rx_sb_empty_i, loop_up_detect_i;
logic [AW-1:0] avs_address_i;
logic [DW-1:0] avs_writedata_i, avs_readdata_o, rd;
logic [3:0] avs_byteenable_i;
logic avs_waitrequest_o, rx_frame_drop_o, rx_frame_repeat_o, loop_up_detect_en_o, irq_o;
logic [RW-1:0] loop_up_code_pattern_o, wd;
logic [AW-1:0] addrs [6];
int miscompares, n_compared, cycles, seed, m_en, m_st, m_det;

rsl_top uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .rx_sb_write_i(rx_sb_write_i),
    .rx_sb_read_i(rx_sb_read_i), .rx_sb_full_i(rx_sb_full_i), .rx_sb_empty_i(rx_sb_empty_i),
    .loop_up_detect_i(loop_up_detect_i), .rx_frame_drop_o(rx_frame_drop_o),
    .rx_frame_repeat_o(rx_frame_repeat_o), .loop_up_code_pattern_o(loop_up_code_pattern_o),
    .loop_up_detect_en_o(loop_up_detect_en_o), .irq_o(irq_o));

////////////////////////////////////////////////////////////
// Clock and hang guard
initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
end

always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
        miscompares++;
        report_and_stop();
    end
end

////////////////////////////////////////////////////////////
// Compare and closing tasks
task automatic chk_reg(input string what, input logic [DW-1:0] exp, input logic [DW-1:0] got);
    n_compared++;
    if (got !== exp) begin
        miscompares++;
        $display("FAIL %s expected %h seen %h", what, exp, got);
    end
endtask

task automatic chk_pin(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
        miscompares++;
        $display("FAIL %s expected %b seen %b", what, exp, got);
    end
endtask

task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
        $display("ALL CHECKS OK");
    end else begin
        $display("CHECKS NOT OK");
    end
    $finish;
endtask

////////////////////////////////////////////////////////////
// Avalon-MM master: hold until waitrequest low, then one idle edge
task automatic bus(input logic wr, input logic [AW-1:0] a, input logic [7:0] d, input logic [3:0] be);
    avs_address_i <= a;
    avs_write_i <= wr;
    avs_read_i <= ~wr;
    avs_writedata_i <= {24'h000000, d};
    avs_byteenable_i <= be;
    // Only the hang guard ends a missing answer
    do begin
        @(posedge clk_i);
    end while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge clk_i);
endtask

task automatic wr_reg(input logic [AW-1:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'hf);
endtask

task automatic rd_chk(input string what, input logic [AW-1:0] a, input int exp);
    bus(1'b0, a, 8'h00, 4'hf);
    chk_reg(what, DW'(exp), rd);
endtask

////////////////////////////////////////////////////////////
// Slip event: a harmless strobe first, then a real slip
task automatic slip_ev(input bit is_full);
    rx_sb_write_i <= is_full;
    rx_sb_read_i <= !is_full;
    @(posedge clk_i);
    rx_sb_full_i <= is_full;
    rx_sb_empty_i <= !is_full;
    @(posedge clk_i);
    chk_pin("no slip drop", 1'b0, rx_frame_drop_o | rx_frame_repeat_o);
    rx_sb_write_i <= 1'b0;
    rx_sb_read_i <= 1'b0;
    rx_sb_full_i <= 1'b0;
    rx_sb_empty_i <= 1'b0;
    m_st = m_st | (is_full ? 5 : 3);
    @(posedge clk_i);
    chk_pin("frame drop", is_full, rx_frame_drop_o);
    chk_pin("frame repeat", !is_full, rx_frame_repeat_o);
    @(posedge clk_i);
    chk_pin("drop pulse end", 1'b0, rx_frame_drop_o | rx_frame_repeat_o);
    chk_pin("irq", (m_st & m_en) != 0, irq_o);
endtask

////////////////////////////////////////////////////////////
// Main sequence
initial begin
    seed = 32'h838b731b;
    {rst_b_i, avs_read_i, avs_write_i, rx_sb_write_i, rx_sb_read_i} = 5'h00;
    {rx_sb_full_i, rx_sb_empty_i, loop_up_detect_i} = 3'h0;
    avs_address_i = '0;
    avs_writedata_i = '0;
    avs_byteenable_i = 4'hf;
    addrs = '{IDX_PATTERN, IDX_SLIP_EN, IDX_LOOP_ST, IDX_SLIP_ST, IDX_LOOP_CTRL, 12'h000};
    m_en = 0;
    m_st = 0;
    repeat (8) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    // Reset values, unmapped place included
    foreach (addrs[k]) rd_chk("reset value", addrs[k], 0);
    chk_pin("irq at reset", 1'b0, irq_o);
    $display("test reset done");

    // Pattern register and ignored writes
    wd = 8'($random(seed));
    wr_reg(IDX_PATTERN, wd);
    rd_chk("pattern", IDX_PATTERN, wd);
    chk_reg("pattern pin", DW'(wd), DW'(loop_up_code_pattern_o));
    bus(1'b1, IDX_SLIP_EN, 8'h07, 4'h0);
    rd_chk("masked write", IDX_SLIP_EN, 0);
    wr_reg(12'h000, 8'hff);
    rd_chk("unmapped", 12'h000, 0);
    $display("test registers done");

    // Every enable mask against both slip kinds
    for (int i = 0; i < 16; i++) begin
        wd = (8'($random(seed)) & 8'hf8) | 8'(i & 7);
        m_en = i & 7;
        wr_reg(IDX_SLIP_EN, wd);
        rd_chk("slip enable", IDX_SLIP_EN, m_en);
        slip_ev(i >= 8);
        rd_chk("slip status", IDX_SLIP_ST, m_st);
        m_st = 0;
        repeat (2) @(posedge clk_i);
        chk_pin("irq after read", 1'b0, irq_o);
        rd_chk("status cleared", IDX_SLIP_ST, 0);
    end
    $display("test slip interrupts done");

    // Write-one-to-clear of a single bit
    slip_ev(1'b1);
    wr_reg(IDX_SLIP_ST, 8'h04);
    m_st = m_st & ~4;
    rd_chk("status w1c", IDX_SLIP_ST, m_st);
    m_st = 0;
    $display("test w1c done");

    // Slip in the read's clearing cycle survives the clear
    slip_ev(1'b0);
    fork
        rd_chk("status before clash", IDX_SLIP_ST, m_st);
        begin
            @(posedge clk_i);
            rx_sb_write_i <= 1'b1;
            rx_sb_full_i <= 1'b1;
            @(posedge clk_i);
            rx_sb_write_i <= 1'b0;
            rx_sb_full_i <= 1'b0;
        end
    join
    m_st = 5;
    rd_chk("set wins over clear", IDX_SLIP_ST, m_st);
    m_st = 0;
    $display("test set wins done");

    // Live loop-up detection, gated by its enable
    for (int k = 0; k < 4; k++) begin
        m_det = (k < 2) ? 1 : 0;
        wr_reg(IDX_LOOP_CTRL, 8'(m_det));
        chk_pin("detect enable", m_det[0], loop_up_detect_en_o);
        loop_up_detect_i <= ~k[0];
        repeat (5) @(posedge clk_i);
        rd_chk("loop status", IDX_LOOP_ST, (m_det & ~k & 1) << 3);
    end
    $display("test detect done");

    // Reset in mid-run returns every register to zero
    wr_reg(IDX_SLIP_EN, 8'h07);
    m_en = 7;
    slip_ev(1'b1);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    chk_pin("irq after reset", 1'b0, irq_o);
    chk_pin("detect enable after reset", 1'b0, loop_up_detect_en_o);
    chk_reg("pattern after reset", DW'(PATTERN_RST), DW'(loop_up_code_pattern_o));
    rd_chk("enable after reset", IDX_SLIP_EN, 0);
    rd_chk("status after reset", IDX_SLIP_ST, 0);
    m_st = 0;
    $display("test second reset done");
    report_and_stop();
end

endmodule
